// File: rcsr_exec.sv
// execution logic for relative subroutine call and software reset
`timescale 1ns/1ps
`default_nettype none
module rcsr_exec (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst_n,
    // instruction decoder, sampled in the first quarter phase
    input  wire rcsr_pkg::rcsr_decode_type       decode,
    input  wire logic                            decode_valid,
    // program counter of the word being executed (already past it)
    input  wire logic [rcsr_pkg::PC_W-1:0]       pc_in,
    // arithmetic status flags from the alu
    input  wire logic [rcsr_pkg::STATUS_W-1:0]   status_in,
    input  wire logic                            status_we,
    // return stack push
    output var  rcsr_pkg::rcsr_stack_type        stack_out,
    // program counter write
    output logic                                 pc_we,
    output logic [rcsr_pkg::PC_W-1:0]            pc_out,
    // status flags as held by the core
    output logic [rcsr_pkg::STATUS_W-1:0]        status_out,
    // reset request to the rest of the core and pipeline flush
    output logic                                 soft_reset_req,
    output logic                                 flush,
    output logic [1:0]                           qphase,
    output logic                                 busy
);

    rcsr_pkg::rcsr_qphase_type           q_reg;
    rcsr_pkg::rcsr_op_type               op_reg;
    logic [rcsr_pkg::OFFS_W-1:0]         offs_reg;
    logic [rcsr_pkg::PC_W-1:0]           base_reg;
    logic                                second_reg;
    logic                                reset_pend_reg;

    // sign-extend and double the word offset into a byte displacement
    function automatic logic [rcsr_pkg::PC_W-1:0] byte_disp(
        input logic [rcsr_pkg::OFFS_W-1:0] n
    );
        logic [rcsr_pkg::PC_W-1:0] ext;
        ext = {{(rcsr_pkg::PC_W-rcsr_pkg::OFFS_W){n[rcsr_pkg::OFFS_W-1]}}, n};
        return {ext[rcsr_pkg::PC_W-2:0], 1'b0};
    endfunction

    // quarter phase sequencer: one instruction cycle is four clocks
    always_ff @(posedge clock) begin
        if (!rst_n || reset_pend_reg) begin
            q_reg <= rcsr_pkg::RCSR_Q1;
        end else begin
            unique case (q_reg)
                rcsr_pkg::RCSR_Q1: q_reg <= rcsr_pkg::RCSR_Q2;
                rcsr_pkg::RCSR_Q2: q_reg <= rcsr_pkg::RCSR_Q3;
                rcsr_pkg::RCSR_Q3: q_reg <= rcsr_pkg::RCSR_Q4;
                rcsr_pkg::RCSR_Q4: q_reg <= rcsr_pkg::RCSR_Q1;
            endcase
        end
    end

    // latch the decoded instruction at q1; the second call cycle decodes nothing
    always_ff @(posedge clock) begin
        if (!rst_n || reset_pend_reg) begin
            op_reg     <= rcsr_pkg::RCSR_OP_NONE;
            offs_reg   <= '0;
            base_reg   <= rcsr_pkg::PC_RESET;
            second_reg <= 1'b0;
        end else if (q_reg == rcsr_pkg::RCSR_Q1) begin
            if (second_reg || !decode_valid) begin
                op_reg <= rcsr_pkg::RCSR_OP_NONE;
            end else begin
                op_reg <= decode.op;
            end
            offs_reg   <= decode.offset;
            base_reg   <= pc_in;
            second_reg <= 1'b0;
        end else if (q_reg == rcsr_pkg::RCSR_Q4) begin
            second_reg <= (op_reg == rcsr_pkg::RCSR_OP_CALL);
        end
    end

    // push happens in q2, strictly before the pc write in q4
    always_ff @(posedge clock) begin
        if (!rst_n || reset_pend_reg) begin
            stack_out <= '0;
        end else begin
            stack_out.push <= (q_reg == rcsr_pkg::RCSR_Q2) &&
                              (op_reg == rcsr_pkg::RCSR_OP_CALL);
            stack_out.push_value <= base_reg;
        end
    end

    // pc_in already points past the call word, so base is call address + 2
    always_ff @(posedge clock) begin
        if (!rst_n || reset_pend_reg) begin
            pc_we  <= 1'b0;
            pc_out <= rcsr_pkg::PC_RESET;
            flush  <= 1'b0;
        end else begin
            pc_we <= (q_reg == rcsr_pkg::RCSR_Q4) &&
                     (op_reg == rcsr_pkg::RCSR_OP_CALL);
            if ((q_reg == rcsr_pkg::RCSR_Q4) &&
                (op_reg == rcsr_pkg::RCSR_OP_CALL)) begin
                pc_out <= base_reg + byte_disp(offs_reg);
            end
            flush <= (q_reg == rcsr_pkg::RCSR_Q4) &&
                     (op_reg == rcsr_pkg::RCSR_OP_CALL);
        end
    end

    // soft reset starts in q2 and is applied to this block on the next edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reset_pend_reg <= 1'b0;
            soft_reset_req <= 1'b0;
        end else begin
            reset_pend_reg <= (q_reg == rcsr_pkg::RCSR_Q2) &&
                              (op_reg == rcsr_pkg::RCSR_OP_SOFT_RESET);
            soft_reset_req <= (q_reg == rcsr_pkg::RCSR_Q2) &&
                              (op_reg == rcsr_pkg::RCSR_OP_SOFT_RESET);
        end
    end

    // flags: call never writes them, soft reset forces the reset value
    always_ff @(posedge clock) begin
        if (!rst_n || reset_pend_reg) begin
            status_out <= rcsr_pkg::STATUS_RESET;
        end else if (status_we && (op_reg != rcsr_pkg::RCSR_OP_CALL)) begin
            status_out <= status_in;
        end
    end

    // soft reset clears the phase copy and busy as well, like master clear
    always_ff @(posedge clock) begin
        if (!rst_n || reset_pend_reg) begin
            qphase <= 2'h0;
            busy   <= 1'b0;
        end else begin
            qphase <= q_reg;
            busy   <= (op_reg != rcsr_pkg::RCSR_OP_NONE) || second_reg;
        end
    end

endmodule // rcsr_exec
`default_nettype wire

// File: rcsr_pkg.sv
// package for the relative call and soft reset execution block
package rcsr_pkg;
    localparam int PC_W     = 21;
    localparam int OFFS_W   = 11;
    localparam int STATUS_W = 5;
    localparam logic [PC_W-1:0]     PC_RESET      = 21'h000000;
    localparam logic [STATUS_W-1:0] STATUS_RESET  = 5'h00;
    localparam logic [PC_W-1:0]     PC_STEP       = 21'h000002;
    localparam int CALL_CYCLES   = 2;
    localparam int RESET_QPHASE  = 1;

    typedef enum logic [1:0] {
        RCSR_Q1,
        RCSR_Q2,
        RCSR_Q3,
        RCSR_Q4
    } rcsr_qphase_type;

    typedef enum logic [1:0] {
        RCSR_OP_NONE,
        RCSR_OP_CALL,
        RCSR_OP_SOFT_RESET
    } rcsr_op_type;

    typedef struct packed {
        rcsr_op_type              op;
        logic [OFFS_W-1:0]        offset;
    } rcsr_decode_type;

    typedef struct packed {
        logic                     push;
        logic [PC_W-1:0]          push_value;
    } rcsr_stack_type;
endpackage

// File: rcsr_exec_chk.sv
// concurrent assertions for the rcsr_exec block
`timescale 1ns/1ps
`default_nettype none
module rcsr_exec_chk (
    // clock, reset and decoder side
    input wire logic                      clock,
    input wire logic                      rst_n,
    input wire rcsr_pkg::rcsr_decode_type decode,
    input wire logic                      decode_valid,
    input wire logic [20:0]               pc_in,
    input wire logic [4:0]                status_in,
    input wire logic                      status_we,
    // core side
    input wire rcsr_pkg::rcsr_stack_type  stack_out,
    input wire logic                      pc_we,
    input wire logic [20:0]               pc_out,
    input wire logic [4:0]                status_out,
    input wire logic                      soft_reset_req,
    input wire logic                      flush,
    input wire logic [1:0]                qphase,
    input wire logic                      busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // busy keeps the ignored second-cycle decode out of the trigger
    wire take = qphase == 2'h3 && decode_valid && !busy;
    sequence call_take;
        take && decode.op == rcsr_pkg::RCSR_OP_CALL;
    endsequence
    chk_push_ret: assert property (call_take |-> ##2 stack_out.push &&
        stack_out.push_value == $past(pc_in, 2)) else $error("bad push");
    chk_pc_target: assert property (call_take |-> ##4 pc_we && flush &&
        pc_out == $past(pc_in, 4) + {{9{$past(decode.offset[10], 4)}},
        $past(decode.offset, 4), 1'b0}) else $error("bad target");
    chk_push_first: assert property (stack_out.push |-> !pc_we ##2 pc_we)
        else $error("push not before pc write");
    chk_nop_cycle: assert property (call_take |-> ##5
        (!stack_out.push && !pc_we && !soft_reset_req)[*4])
        else $error("second cycle not idle");
    chk_call_flags: assert property (call_take |-> ##1
        ($stable(status_out))[*5]) else $error("call changed flags");
    chk_reset_req: assert property (take &&
        decode.op == rcsr_pkg::RCSR_OP_SOFT_RESET |-> ##2 soft_reset_req)
        else $error("no reset request");
    chk_reset_vals: assert property (soft_reset_req |=> !busy &&
        status_out == rcsr_pkg::STATUS_RESET && pc_out == rcsr_pkg::PC_RESET)
        else $error("state not reset");
    // busy lags the latched call by one clock, so the edge after the take edge is excluded
    chk_flag_write: assert property (status_we && !busy && !decode_valid &&
        !$past(take)
        |=> status_out == $past(status_in)) else $error("flag write lost");
endmodule // rcsr_exec_chk
bind rcsr_exec rcsr_exec_chk chk_u (.*);
`default_nettype wire

// File: rcsr_exec_tb_top.sv
// self-checking bench for the rcsr_exec block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module rcsr_exec_tb_top;
    logic                      clock = 0, rst_n = 0, decode_valid = 0;
    logic                      status_we = 0, pc_we, soft_reset_req, flush, busy;
    rcsr_pkg::rcsr_decode_type decode = '0;
    rcsr_pkg::rcsr_stack_type  stack_out;
    logic [20:0]               pc_in = '0, pc_out;
    logic [4:0]                status_in = '0, status_out;
    logic [1:0]                qphase;
    int                        fails = 0, checks_done = 0, cyc = 0;
    always #5 clock = ~clock;
    rcsr_exec dut_u (.*);
    // qphase lags one clock, so 2 here means the edge after next is a take edge
    task automatic issue(rcsr_pkg::rcsr_op_type op, logic [10:0] n,
                         logic [20:0] pc);
        while (qphase !== 2'h2) @(negedge clock);
        @(posedge clock);
        decode <= '{op, n};
        pc_in <= pc;
        decode_valid <= 1'b1;
        @(posedge clock);
        decode_valid <= 1'b0;
    endtask
    task automatic t_call(logic [10:0] n, logic [20:0] pc);
        status_in <= 5'h0a;
        status_we <= 1'b1;
        @(posedge clock);
        status_we <= 1'b0;
        issue(rcsr_pkg::RCSR_OP_CALL, n, pc);
        status_in <= 5'h15;
        status_we <= 1'b1;
        @(posedge clock);
        #1 `CHK("push", 1'b1, stack_out.push)
        `CHK("ret", pc, stack_out.push_value)
        repeat (2) @(posedge clock);
        #1 `CHK("pc_we", 1'b1, pc_we)
        `CHK("target", pc + {{9{n[10]}}, n, 1'b0}, pc_out)
        status_we <= 1'b0;
        // a decode at the q1 of the second cycle must be dropped
        decode <= '{rcsr_pkg::RCSR_OP_CALL, n};
        decode_valid <= 1'b1;
        @(posedge clock);
        decode_valid <= 1'b0;
        @(posedge clock);
        #1 `CHK("no push", 1'b0, stack_out.push)
        `CHK("flags", 5'h0a, status_out)
        $display("call test done");
    endtask
    task automatic t_reset;
        issue(rcsr_pkg::RCSR_OP_SOFT_RESET, 11'h000, 21'h000000);
        @(posedge clock);
        #1 `CHK("req", 1'b1, soft_reset_req)
        @(posedge clock);
        #1 `CHK("pc", rcsr_pkg::PC_RESET, pc_out)
        `CHK("st", rcsr_pkg::STATUS_RESET, status_out)
        $display("reset test done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_call(11'h005, 21'h000100);
        t_call(11'h400, 21'h001000);
        t_call(11'h3ff, 21'h1ffffe);
        t_reset();
        conclude();
    end
endmodule // rcsr_exec_tb_top
`default_nettype wire
